// *** hdl/host_command_link_handshake.sv ***
// Handshake state machine for the host command link
`timescale 1ns/1ps
`default_nettype none
module host_command_link_handshake
	import cmd_link_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = REPLY_TIMEOUT_CYC,
	parameter int unsigned MAX_RESEND = RESEND_LIMIT
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Receive framer events, one-cycle pulses
	// Framer and host must share serial settings
	input wire logic rx_cmd_ok_in,
	input wire logic rx_error_in,
	input wire logic rx_ack_in,
	input wire logic rx_nak_in,
	// Panel side: outgoing event request
	input wire logic panel_req_in,
	output logic panel_ready_out,
	// Transmit framer strobes
	output logic tx_cmd_out,
	output logic tx_ack_out,
	output logic tx_nak_out,
	// Display update strobe and status
	output logic display_update_out,
	output logic send_done_out,
	output logic send_fail_out,
	output logic busy_out,
	output logic [CNT_W-1:0] resend_count_out
);
	link_state_t state_reg, state_next;
	logic [CNT_W-1:0] resend_reg, resend_next;
	logic tx_cmd_reg, tx_cmd_next;
	logic tx_ack_reg, tx_ack_next;
	logic tx_nak_reg, tx_nak_next;
	logic disp_reg, disp_next;
	logic done_reg, done_next;
	logic fail_reg, fail_next;
	logic timeout;
	logic retry_ev;

	// Reply timer restarts on each command sent
	reply_timer #(
		.TIMEOUT_CYC(TIMEOUT_CYC)
	) u_timer (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.restart_in(tx_cmd_reg),
		.run_in(state_reg == ST_AFTER_SEND),
		.expired_out(timeout)
	);

	// Events that force a resend; a timer pulse in a fresh send's cycle is stale
	// and belongs to the previous attempt, so it is dropped
	assign retry_ev = (timeout && !tx_cmd_reg) || rx_nak_in || rx_error_in;

	// Next-state logic
	always_comb begin
		state_next = state_reg;
		resend_next = resend_reg;
		tx_cmd_next = 1'b0;
		tx_ack_next = 1'b0;
		tx_nak_next = 1'b0;
		disp_next = 1'b0;
		done_next = 1'b0;
		fail_next = 1'b0;
		// Incoming commands are answered in either state
		if (rx_cmd_ok_in) begin
			tx_ack_next = 1'b1;
			disp_next = 1'b1;
		end
		unique case (state_reg)
			// Waiting: answer errors, else start a panel send
			ST_WAITING: begin
				if (rx_error_in) begin
					tx_nak_next = 1'b1;
				end else if (panel_req_in && !rx_cmd_ok_in) begin
					tx_cmd_next = 1'b1;
					resend_next = CNT_ZERO;
					state_next = ST_AFTER_SEND;
				end
			end
			// After sending: ACK ends, resend events count
			ST_AFTER_SEND: begin
				if (rx_ack_in) begin
					done_next = 1'b1;
					state_next = ST_WAITING;
				end else if (retry_ev) begin
					if (resend_reg >= CNT_W'(MAX_RESEND)) begin
						fail_next = 1'b1;
						state_next = ST_WAITING;
					end else begin
						resend_next = resend_reg + CNT_ONE;
						tx_cmd_next = 1'b1;
					end
				end
			end
		endcase
	end

	// Register stage
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg <= ST_WAITING;
			resend_reg <= CNT_ZERO;
			tx_cmd_reg <= 1'b0;
			tx_ack_reg <= 1'b0;
			tx_nak_reg <= 1'b0;
			disp_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			resend_reg <= resend_next;
			tx_cmd_reg <= tx_cmd_next;
			tx_ack_reg <= tx_ack_next;
			tx_nak_reg <= tx_nak_next;
			disp_reg <= disp_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
		end
	end

	// Outputs
	assign panel_ready_out = (state_reg == ST_WAITING) && !rx_cmd_ok_in && !rx_error_in;
	assign tx_cmd_out = tx_cmd_reg;
	assign tx_ack_out = tx_ack_reg;
	assign tx_nak_out = tx_nak_reg;
	assign display_update_out = disp_reg;
	assign send_done_out = done_reg;
	assign send_fail_out = fail_reg;
	assign busy_out = (state_reg == ST_AFTER_SEND);
	assign resend_count_out = resend_reg;

	// Checks
	AST_GOOD_CMD_ACK: assert property (@(posedge clk_in) disable iff (srst_in)
		rx_cmd_ok_in |=> tx_ack_out && display_update_out)
		else $error("good command not acknowledged");
	AST_WAIT_ERR_NAK: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_reg == ST_WAITING) && rx_error_in |=> tx_nak_out && !busy_out)
		else $error("receive error while waiting not answered with NAK");
	AST_ACK_ENDS: assert property (@(posedge clk_in) disable iff (srst_in)
		busy_out && rx_ack_in |=> !busy_out && send_done_out)
		else $error("ACK did not end the send");
	AST_RETRY_SEND: assert property (@(posedge clk_in) disable iff (srst_in)
		busy_out && !rx_ack_in && retry_ev && resend_reg < CNT_W'(MAX_RESEND)
		|=> tx_cmd_out && busy_out && resend_reg == $past(resend_reg) + CNT_ONE)
		else $error("resend not issued");
	AST_RETRY_GIVEUP: assert property (@(posedge clk_in) disable iff (srst_in)
		busy_out && !rx_ack_in && retry_ev && resend_reg >= CNT_W'(MAX_RESEND)
		|=> send_fail_out && !busy_out && !tx_cmd_out)
		else $error("resend limit not enforced");
	AST_START_SEND: assert property (@(posedge clk_in) disable iff (srst_in)
		panel_req_in && panel_ready_out |=> tx_cmd_out && busy_out && resend_reg == CNT_ZERO)
		else $error("panel request not sent");
	AST_COUNT_BOUND: assert property (@(posedge clk_in) disable iff (srst_in)
		resend_reg <= CNT_W'(MAX_RESEND))
		else $error("resend count over limit");
	AST_IDLE_ACCEPT: assert property (@(posedge clk_in) disable iff (srst_in)
		!busy_out && rx_cmd_ok_in |-> !panel_ready_out ##1 (!tx_cmd_out && !busy_out))
		else $error("panel start collided with incoming command");
	// Host command while sending is answered, send goes on
	AST_CMD_IN_SEND: assert property (@(posedge clk_in) disable iff (srst_in)
		busy_out && rx_cmd_ok_in && !rx_ack_in && !retry_ev |=> busy_out && tx_ack_out)
		else $error("command during send not answered");
	// Receive error while sending is a resend event (resend or give-up), never a NAK
	AST_NO_NAK_BUSY: assert property (@(posedge clk_in) disable iff (srst_in)
		busy_out && rx_error_in |=> !tx_nak_out)
		else $error("NAK sent while waiting for a reply");
	// Stray ACK or NAK while waiting is ignored
	AST_WAIT_IGNORES_REPLY: assert property (@(posedge clk_in) disable iff (srst_in)
		!busy_out && !panel_req_in && (rx_ack_in || rx_nak_in)
		|=> !busy_out && !send_done_out && !send_fail_out && !tx_cmd_out)
		else $error("stray reply acted on while waiting");
	// No resend without a resend event
	AST_NO_RESEND_IDLE: assert property (@(posedge clk_in) disable iff (srst_in)
		busy_out && !retry_ev |=> !tx_cmd_out)
		else $error("resend without cause");
	// A stale timer pulse must not resend twice
	AST_NO_STALE_TIMEOUT: assert property (@(posedge clk_in) disable iff (srst_in)
		tx_cmd_out && !rx_nak_in && !rx_error_in |=> !tx_cmd_out)
		else $error("back to back send without reply");
	// Reset leaves the link waiting and quiet
	AST_RESET_IDLE: assert property (@(posedge clk_in)
		srst_in |=> !busy_out && !tx_cmd_out && !send_fail_out && resend_count_out == CNT_ZERO)
		else $error("link not idle after reset");
	// Display updates only follow a good command
	AST_DISP_FROM_CMD: assert property (@(posedge clk_in) disable iff (srst_in)
		display_update_out |-> $past(rx_cmd_ok_in))
		else $error("display update without command");
	// Count holds while waiting unless a send starts
	AST_COUNT_STABLE: assert property (@(posedge clk_in) disable iff (srst_in)
		!busy_out && !(panel_req_in && panel_ready_out) |=> $stable(resend_count_out))
		else $error("resend count moved while waiting");
	// Timer expiry resends or gives up
	AST_TIMEOUT_RETRY: assert property (@(posedge clk_in) disable iff (srst_in)
		busy_out && timeout && !tx_cmd_out && !rx_ack_in |=> tx_cmd_out || send_fail_out)
		else $error("reply timeout ignored");
	// Done only after an ACK
	AST_DONE_ONLY_ACK: assert property (@(posedge clk_in) disable iff (srst_in)
		send_done_out |-> $past(rx_ack_in) && !busy_out)
		else $error("send done without ACK");
	// Give-up only at the resend limit
	AST_FAIL_AT_LIMIT: assert property (@(posedge clk_in) disable iff (srst_in)
		send_fail_out |-> !busy_out && $past(resend_reg) == CNT_W'(MAX_RESEND))
		else $error("gave up below the resend limit");
	// ACK wins over a resend event in the same cycle
	AST_ACK_BEATS_RETRY: assert property (@(posedge clk_in) disable iff (srst_in)
		busy_out && rx_ack_in && retry_ev |=> send_done_out && !tx_cmd_out && !send_fail_out)
		else $error("resend event beat ACK");
	// ACK strobe only after a good command
	AST_ACK_FROM_CMD: assert property (@(posedge clk_in) disable iff (srst_in)
		tx_ack_out |-> $past(rx_cmd_ok_in))
		else $error("ACK sent without command");
	// NAK strobe only after an error while waiting
	AST_NAK_FROM_ERR: assert property (@(posedge clk_in) disable iff (srst_in)
		tx_nak_out |-> $past(rx_error_in) && !busy_out)
		else $error("NAK sent without receive error");
	// Main scenarios
	COV_SEND_ACK: cover property (@(posedge clk_in) tx_cmd_out ##[1:20] send_done_out);
	COV_RETRY: cover property (@(posedge clk_in) busy_out && retry_ev ##1 tx_cmd_out);
	COV_FAIL: cover property (@(posedge clk_in) send_fail_out);
	COV_CMD_IN_SEND: cover property (@(posedge clk_in) busy_out && rx_cmd_ok_in);
	COV_REQ_COLLIDE: cover property (@(posedge clk_in) !busy_out && panel_req_in && rx_cmd_ok_in);
endmodule : host_command_link_handshake
`default_nettype wire

// *** hdl/cmd_link_pkg.sv ***
// Constants and types for the host command link handshake
package cmd_link_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned REPLY_TIMEOUT_US = 1000;
	localparam int unsigned REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_US * CLK_MHZ;
	localparam int unsigned RESEND_LIMIT = 2;
	localparam int unsigned CNT_W = 4;
	localparam int unsigned TMR_W = 24;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
	localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;

	typedef enum logic [1:0] {
		ST_WAITING = 2'h1,
		ST_AFTER_SEND = 2'h2
	} link_state_t;
endpackage : cmd_link_pkg

// *** hdl/reply_timer.sv ***
// Reply timeout counter for the after-sending state
`timescale 1ns/1ps
`default_nettype none
module reply_timer
	import cmd_link_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = REPLY_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Control
	input wire logic restart_in,
	input wire logic run_in,
	// Status
	output logic expired_out
);
	logic [TMR_W-1:0] count_reg;
	logic [TMR_W-1:0] count_next;
	logic expired_reg;
	logic expired_next;

	// Count up while running, pulse at the limit
	always_comb begin
		count_next = count_reg;
		expired_next = 1'b0;
		if (restart_in || !run_in) begin
			count_next = TMR_ZERO;
		end else if (count_reg == TMR_W'(TIMEOUT_CYC - 1)) begin
			count_next = TMR_ZERO;
			expired_next = 1'b1;
		end else begin
			count_next = count_reg + TMR_ONE;
		end
	end

	// Register stage
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			count_reg <= TMR_ZERO;
			expired_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			expired_reg <= expired_next;
		end
	end

	assign expired_out = expired_reg;
endmodule : reply_timer
`default_nettype wire

// *** dv/host_model.sv ***
// Behavioural host computer that answers panel commands
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock and stimulus control
	input wire logic clk_in,
	input wire logic [1:0] mode_in,
	input wire logic [2:0] delay_in,
	input wire logic cmd_in,
	input wire logic err_in,
	input wire logic tx_cmd_in,
	// Receive events towards the panel
	output logic rx_cmd_ok_out = 1'b0,
	output logic rx_error_out = 1'b0,
	output logic rx_ack_out = 1'b0,
	output logic rx_nak_out = 1'b0
);
	int wait_cnt = -1;
	// Reply after a delay: ACK, NAK, silence or a garbled frame
	always @(negedge clk_in) begin
		rx_cmd_ok_out <= cmd_in;
		rx_error_out <= err_in || (wait_cnt == 0 && mode_in == 2'h3);
		rx_ack_out <= wait_cnt == 0 && mode_in == 2'h0;
		rx_nak_out <= wait_cnt == 0 && mode_in == 2'h1;
		if (tx_cmd_in)
			wait_cnt <= delay_in;
		else if (wait_cnt >= 0)
			wait_cnt <= wait_cnt - 1;
	end
endmodule // host_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the host command link handshake
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
	import cmd_link_pkg::*;
	logic clk_in = 0, srst_in = 1, req = 0, cmd = 0, err = 0, clr = 1;
	logic [1:0] mode = 0;
	logic [2:0] dly = 0;
	logic rc, re, ra, rn, ready, txc, txa, txn, disp, done, fail, busy;
	logic [CNT_W-1:0] cnt;
	logic [31:0] seed = 32'h0000003F;
	int err_count = 0, num_checks = 0, cyc = 0, n;
	int k[6];
	host_model host_u (.clk_in(clk_in), .mode_in(mode), .delay_in(dly), .cmd_in(cmd),
		.err_in(err), .tx_cmd_in(txc), .rx_cmd_ok_out(rc), .rx_error_out(re),
		.rx_ack_out(ra), .rx_nak_out(rn));
	host_command_link_handshake #(.TIMEOUT_CYC(50)) dut_u (.clk_in(clk_in), .srst_in(srst_in),
		.rx_cmd_ok_in(rc), .rx_error_in(re), .rx_ack_in(ra), .rx_nak_in(rn),
		.panel_req_in(req), .panel_ready_out(ready), .tx_cmd_out(txc), .tx_ack_out(txa),
		.tx_nak_out(txn), .display_update_out(disp), .send_done_out(done),
		.send_fail_out(fail), .busy_out(busy), .resend_count_out(cnt));
	initial forever #2.5 clk_in = ~clk_in;
	// Pulse tallies and run limit
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
		if (clr)
			k = '{default: 0};
		else begin
			k[0] += txc; k[1] += txa; k[2] += txn;
			k[3] += disp; k[4] += done; k[5] += fail;
		end
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int exp_tx(int m);
		return (m == 0) ? 1 : 1 + RESEND_LIMIT;
	endfunction
	function automatic logic [CNT_W-1:0] exp_cnt(int m);
		return (m == 0) ? CNT_ZERO : CNT_W'(RESEND_LIMIT);
	endfunction
	// One outgoing event; c: 0 plain, 1 host command mid-send, 2 command beats request
	task automatic send(int m, int c);
		clr = 1;
		mode <= 2'(m);
		dly <= 3'(xs());
		@(negedge clk_in);
		clr = 0;
		if (c == 2) begin
			cmd <= 1'b1;
			@(negedge clk_in);
			cmd <= 1'b0;
		end
		req = 1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (ready !== 1'b1 && n < 50);
		@(negedge clk_in);
		req = 0;
		`CHK(n, 1 + int'(c == 2))
		`CHK(ready, 1'b0)
		`CHK(busy, 1'b1)
		if (c == 1) begin
			cmd <= 1'b1;
			@(negedge clk_in);
			cmd <= 1'b0;
		end
		n = 0;
		while (busy !== 1'b0 && n < 500) begin
			@(negedge clk_in);
			n++;
		end
		@(negedge clk_in);
		`CHK(k[0], exp_tx(m))
		`CHK(k[4], int'(m == 0))
		`CHK(k[5], int'(m != 0))
		`CHK(k[1], int'(c != 0))
		`CHK(k[3], int'(c != 0))
		`CHK(k[2], 0)
		`CHK(cnt, exp_cnt(m))
		$display("test send mode %0d case %0d finished", m, c);
	endtask
	// Unsolicited host frame, good or garbled
	task automatic host(bit e);
		clr = 1;
		@(negedge clk_in);
		clr = 0;
		cmd <= !e;
		err <= e;
		@(negedge clk_in);
		cmd <= 0;
		err <= 0;
		repeat (3) @(negedge clk_in);
		`CHK(k[1], int'(!e))
		`CHK(k[3], int'(!e))
		`CHK(k[2], int'(e))
		$display("test host frame error=%0d finished", e);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(negedge clk_in);
		srst_in = 0;
		`CHK(ready, 1'b1)
		for (int r = 0; r < 3; r++)
			for (int m = 0; m < 4; m++)
				send(m, int'(xs() % 3));
		send(2, 1);
		send(0, 2);
		send(1, 2);
		host(0);
		host(1);
		print_verdict();
	end
endmodule // tb
`default_nettype wire
